// [rtl/wdtu_regs.vh]
`ifndef WDTU_REGS_VH
`define WDTU_REGS_VH
// register select codes on the cpu port
`define WDTU_SEL_COUNTER      1'b0
`define WDTU_SEL_CTRL         1'b1
// access sizes
`define WDTU_SIZE_BYTE        2'b00
`define WDTU_SIZE_WORD        2'b01
`define WDTU_SIZE_LONG        2'b10
// write keys
`define WDTU_KEY_COUNTER      8'h5A
`define WDTU_KEY_CTRL         8'hA5
// control/status fields
`define WDTU_BIT_ENABLE       7
`define WDTU_BIT_MODE         6
`define WDTU_BIT_RSTSEL       5
`define WDTU_BIT_WATCHDOG_OVERFLOW_FLAG         4
`define WDTU_BIT_INTERVAL_OVERFLOW_FLAG         3
`define WDTU_CKS_HI           2
`define WDTU_CKS_LO           0
// reset values
`define WDTU_COUNTER_RESET    8'h00
`define WDTU_CTRL_RESET       8'h00
`define WDTU_COUNT_MAX        8'hFF
// prescaler width, covers divide by 4096
`define WDTU_PRE_W            12
`define WDTU_DIV_SLOW_MIN     3'h2
`endif

// [rtl/wdtu_top.v]
// Functional notes
// - 8-bit counter steps on selected count enable
// - counter cleared only by power-on reset
// - counter write needs word access, key 5A
// - control/status cleared only by power-on reset
// - control write needs word access, key A5
// - byte or long writes change nothing
// - bit 7 enables counting, else count held except while settling
// - bit 6 picks watchdog or interval mode
// - bit 5 picks power-on or manual reset
// - watchdog overflow sets watchdog flag only
// - interval overflow sets interval flag only
// - clock select divides by 1..4096
// - watchdog overflow requests chosen reset
// - interval overflow raises interrupt request
// - manual reset at slow divide fires twice
// - settling overflow leaves control/status unchanged
// - settling count delays clock restart
// - settling overflow signals clock restart, no flag
// - frequency-change settling stops counter at 00
// - normal overflow wraps and keeps counting
`timescale 1ns/1ps
`include "wdtu_regs.vh"

module wdtu_top
(
   input  wire        MCLK_I,
   input  wire        RESET_I,
   input  wire        WR_I,
   input  wire        SEL_I,
   input  wire [1:0]  SIZE_I,
   input  wire [15:0] WDATA_I,
   input  wire        RSEL_I,
   input  wire        STBY_SETTLE_I,
   input  wire        FREQ_SETTLE_I,
   output wire [7:0]  RDATA_O,
   output reg         POR_REQ_O,
   output reg         MANRST_REQ_O,
   output reg         INTERVAL_IRQ_O,
   output reg         CLK_RESTART_O
);

   // ==========================================================
   // state
   reg  [7:0]              counter;
   reg  [7:0]              ctrl;
   reg  [`WDTU_PRE_W-1:0]  prescale;
   reg                     freq_stopped;
   reg                     second_pending;
   reg                     man_first;
   reg                     tick;
   wire                    settling;
   wire                    run;
   wire                    overflow;
   wire                    wr_cnt;
   wire                    wr_ctl;
   wire [2:0]              cks;
   wire [`WDTU_PRE_W-1:0]  next_prescale;

   assign cks = ctrl[`WDTU_CKS_HI:`WDTU_CKS_LO];
   assign settling = STBY_SETTLE_I | FREQ_SETTLE_I;

   // ==========================================================
   // register access
   // keyed word writes only
   assign wr_cnt = WR_I & (SIZE_I == `WDTU_SIZE_WORD) & (SEL_I == `WDTU_SEL_COUNTER)
                   & (WDATA_I[15:8] == `WDTU_KEY_COUNTER);
   assign wr_ctl = WR_I & (SIZE_I == `WDTU_SIZE_WORD) & (SEL_I == `WDTU_SEL_CTRL)
                   & (WDATA_I[15:8] == `WDTU_KEY_CTRL);
   assign RDATA_O = (RSEL_I == `WDTU_SEL_CTRL) ? ctrl : counter;

   // ==========================================================
   // prescaler
   // free-running, single-cycle enable
   assign next_prescale = prescale + {{(`WDTU_PRE_W-1){1'b0}}, 1'b1};

   always @*
   begin
      case (cks)
         3'h0:    tick = 1'b1;
         3'h1:    tick = (next_prescale[1:0] == 2'h0);
         3'h2:    tick = (next_prescale[3:0] == 4'h0);
         3'h3:    tick = (next_prescale[4:0] == 5'h00);
         3'h4:    tick = (next_prescale[5:0] == 6'h00);
         3'h5:    tick = (next_prescale[7:0] == 8'h00);
         3'h6:    tick = (next_prescale[9:0] == 10'h000);
         default: tick = (next_prescale == 12'h000);
      endcase
   end

   always @(posedge MCLK_I)
   begin
      if (RESET_I)
         prescale <= {`WDTU_PRE_W{1'b0}};
      else
         prescale <= next_prescale;
   end

   // ==========================================================
   // counter
   // enable or settling count runs it
   assign run = (ctrl[`WDTU_BIT_ENABLE] | settling) & ~freq_stopped;
   assign overflow = run & tick & (counter == `WDTU_COUNT_MAX);

   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         counter      <= `WDTU_COUNTER_RESET;
         freq_stopped <= 1'b0;
      end
      else
      begin
         // hold at 00 after a frequency-settling overflow until settling ends
         if (overflow & FREQ_SETTLE_I)
            freq_stopped <= 1'b1;
         else if (~FREQ_SETTLE_I)
            freq_stopped <= 1'b0;
         if (wr_cnt)
            counter <= WDATA_I[7:0];
         else if (run & tick)
            counter <= counter + 8'h01;
      end
   end

   // ==========================================================
   // control/status
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
         ctrl <= `WDTU_CTRL_RESET;
      else
      begin
         if (wr_ctl)
         begin
            ctrl[7:5] <= WDATA_I[7:5];
            ctrl[2:0] <= WDATA_I[2:0];
            // flags clear on 0, never set by 1
            ctrl[`WDTU_BIT_WATCHDOG_OVERFLOW_FLAG] <= ctrl[`WDTU_BIT_WATCHDOG_OVERFLOW_FLAG] & WDATA_I[`WDTU_BIT_WATCHDOG_OVERFLOW_FLAG];
            ctrl[`WDTU_BIT_INTERVAL_OVERFLOW_FLAG] <= ctrl[`WDTU_BIT_INTERVAL_OVERFLOW_FLAG] & WDATA_I[`WDTU_BIT_INTERVAL_OVERFLOW_FLAG];
         end
         // settling overflow sets no flag
         // set wins over a simultaneous clear
         if (overflow & ~settling)
         begin
            if (ctrl[`WDTU_BIT_MODE])
               ctrl[`WDTU_BIT_WATCHDOG_OVERFLOW_FLAG] <= 1'b1;
            else
               ctrl[`WDTU_BIT_INTERVAL_OVERFLOW_FLAG] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // request outputs
   always @(posedge MCLK_I)
   begin
      if (RESET_I)
      begin
         POR_REQ_O      <= 1'b0;
         MANRST_REQ_O   <= 1'b0;
         INTERVAL_IRQ_O <= 1'b0;
         CLK_RESTART_O  <= 1'b0;
         second_pending <= 1'b0;
         man_first      <= 1'b0;
      end
      else
      begin
         CLK_RESTART_O  <= overflow & settling;
         INTERVAL_IRQ_O <= overflow & ~settling & ~ctrl[`WDTU_BIT_MODE];
         POR_REQ_O      <= overflow & ~settling & ctrl[`WDTU_BIT_MODE] & ~ctrl[`WDTU_BIT_RSTSEL];
         // second manual pulse at slow divide
         MANRST_REQ_O   <= (overflow & ~settling & ctrl[`WDTU_BIT_MODE] & ctrl[`WDTU_BIT_RSTSEL])
                           | second_pending;
         // idle cycle between the two pulses keeps them distinct
         // only the overflow pulse arms a repeat, so no endless chain
         man_first      <= overflow & ~settling & ctrl[`WDTU_BIT_MODE] & ctrl[`WDTU_BIT_RSTSEL]
                           & (cks >= `WDTU_DIV_SLOW_MIN);
         second_pending <= man_first;
      end
   end

endmodule

// [verif/watchdog_interval_timer_bench.sv]
`timescale 1ns/1ps
module watchdog_interval_timer_bench;
reg mclk = 1'b0, rst = 1'b1, we = 1'b0, sel = 1'b0, rsel = 1'b0, sg = 1'b0, fg = 1'b0;
reg [1:0] size = 2'h1;
reg [15:0] wdata = 16'h0000;
wire [7:0] rdata;
wire [3:0] ev;
wire stby, freq;
integer bad_count = 0, compares = 0, cyc = 0;
initial forever #10 mclk = ~mclk;
wdtu_top uut (.MCLK_I(mclk), .RESET_I(rst), .WR_I(we), .SEL_I(sel), .SIZE_I(size),
   .WDATA_I(wdata), .RSEL_I(rsel), .STBY_SETTLE_I(stby), .FREQ_SETTLE_I(freq), .RDATA_O(rdata),
   .POR_REQ_O(ev[1]), .MANRST_REQ_O(ev[2]), .INTERVAL_IRQ_O(ev[0]), .CLK_RESTART_O(ev[3]));
wdtu_cgen_model cg (.clk_i(mclk), .rst_i(rst), .stby_go_i(sg), .freq_go_i(fg),
   .restart_i(ev[3]), .stby_o(stby), .freq_o(freq));
task results;
begin
   $display("compares %0d bad %0d", compares, bad_count);
   if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
   else
      $display("Testbench failed");
   $finish;
end
endtask
task chk(input string what, input [7:0] exp, input [7:0] got);
begin
   compares = compares + 1;
   if (got !== exp)
   begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
   end
end
endtask
task put_reg(input s, input [1:0] z, input [15:0] d);
begin
   @(posedge mclk);
   {we, sel, size, wdata} <= {1'b1, s, z, d};
   @(posedge mclk);
   we <= 1'b0;
end
endtask
task get_reg(input s, input [7:0] exp);
begin
   @(posedge mclk);
   rsel <= s;
   @(posedge mclk) #1 chk("rdata", exp, rdata);
end
endtask
task wait_ev(input integer i);
   while (ev[i] !== 1'b1) @(posedge mclk) #1;
endtask
always @(posedge mclk)
begin
   cyc = cyc + 1;
   if (cyc == 5000)
   begin
      bad_count = bad_count + 1;
      results;
   end
end
initial
begin
   repeat (5) @(posedge mclk);
   rst <= 1'b0;
   get_reg(0, 8'h00);
   get_reg(1, 8'h00);
   put_reg(0, 2'h1, 16'h5A33);
   put_reg(0, 2'h0, 16'h5A44);
   put_reg(0, 2'h2, 16'h5A44);
   put_reg(0, 2'h1, 16'hA544);
   get_reg(0, 8'h33);
   put_reg(1, 2'h1, 16'hA51F);
   put_reg(1, 2'h0, 16'hA5E0);
   get_reg(1, 8'h07);
   put_reg(0, 2'h1, 16'h5AFE);
   put_reg(1, 2'h1, 16'hA580);
   wait_ev(0);
   get_reg(1, 8'h88);
   put_reg(1, 2'h1, 16'hA500);
   get_reg(1, 8'h00);
   put_reg(0, 2'h1, 16'h5AFF);
   put_reg(1, 2'h1, 16'hA5C0);
   wait_ev(1);
   get_reg(1, 8'hD0);
   put_reg(1, 2'h1, 16'hA500);
   put_reg(0, 2'h1, 16'h5AFF);
   put_reg(1, 2'h1, 16'hA5E2);
   wait_ev(2);
   @(posedge mclk) #1 chk("man gap", 8'h00, {7'h00, ev[2]});
   @(posedge mclk) #1 chk("man again", 8'h01, {7'h00, ev[2]});
   @(posedge mclk) #1 chk("man third", 8'h00, {7'h00, ev[2]});
   put_reg(1, 2'h1, 16'hA501);
   put_reg(0, 2'h1, 16'h5AFF);
   sg <= 1'b1;
   @(posedge mclk) sg <= 1'b0;
   wait_ev(3);
   get_reg(1, 8'h01);
   put_reg(1, 2'h1, 16'hA500);
   put_reg(0, 2'h1, 16'h5AFE);
   {rsel, fg} <= 2'h1;
   @(posedge mclk) fg <= 1'b0;
   wait_ev(3);
   @(posedge mclk) #1 chk("held", 8'h00, rdata);
   get_reg(1, 8'h00);
   results;
end
endmodule

// [verif/wdtu_cgen_model.sv]
`timescale 1ns/1ps
module wdtu_cgen_model
(
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       stby_go_i,
   input  wire       freq_go_i,
   input  wire       restart_i,
   output reg        stby_o,
   output reg        freq_o
);
reg [2:0] hold;
// settle level
// drops four cycles after restart, so the hold window is seen
always @(posedge clk_i)
   if (rst_i || hold == 3'h4)
      {stby_o, freq_o, hold} <= 5'h00;
   else if (restart_i || hold != 3'h0)
      hold <= hold + 3'h1;
   else
      {stby_o, freq_o} <= {stby_o | stby_go_i, freq_o | freq_go_i};
endmodule

// [verif/wdtu_monitor.sv]
`timescale 1ns/1ps
module wdtu_monitor
(
   input wire        MCLK_I,
   input wire        RESET_I,
   input wire        WR_I,
   input wire        SEL_I,
   input wire [1:0]  SIZE_I,
   input wire [15:0] WDATA_I,
   input wire        RSEL_I,
   input wire        STBY_SETTLE_I,
   input wire        FREQ_SETTLE_I,
   input wire [7:0]  RDATA_O,
   input wire        POR_REQ_O,
   input wire        MANRST_REQ_O,
   input wire        INTERVAL_IRQ_O,
   input wire        CLK_RESTART_O
);
// ==========
// keyed writes and request pulses
default clocking @(posedge MCLK_I); endclocking
default disable iff (RESET_I);
wire wr_word = WR_I && SIZE_I == 2'h1;
cnt_write_a: assert property (wr_word && !SEL_I && WDATA_I[15:8] == 8'h5A ##1 !RSEL_I
   |-> RDATA_O == $past(WDATA_I[7:0])) else $error("counter write lost");
ctl_write_a: assert property (wr_word && SEL_I && WDATA_I[15:8] == 8'hA5 ##1 RSEL_I
   |-> {RDATA_O[7:5], RDATA_O[2:0]} == {$past(WDATA_I[7:5]), $past(WDATA_I[2:0])})
   else $error("control write lost");
irq_pulse_a: assert property (INTERVAL_IRQ_O |=> !INTERVAL_IRQ_O) else $error("irq too long");
por_pulse_a: assert property (POR_REQ_O |=> !POR_REQ_O) else $error("por too long");
man_pulse_a: assert property (MANRST_REQ_O |=> !MANRST_REQ_O) else $error("manual too long");
req_excl_a: assert property (POR_REQ_O |-> !MANRST_REQ_O && !INTERVAL_IRQ_O)
   else $error("requests overlap");
restart_cause_a: assert property (CLK_RESTART_O |-> $past(STBY_SETTLE_I || FREQ_SETTLE_I)
   && !POR_REQ_O && !INTERVAL_IRQ_O) else $error("bad restart");
freq_hold_a: assert property (CLK_RESTART_O && FREQ_SETTLE_I ##1 FREQ_SETTLE_I && !WR_I && !RSEL_I
   |-> RDATA_O == 8'h00) else $error("counter not held");
endmodule
bind wdtu_top wdtu_monitor mon (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .WR_I(WR_I), .SEL_I(SEL_I),
   .SIZE_I(SIZE_I), .WDATA_I(WDATA_I), .RSEL_I(RSEL_I), .STBY_SETTLE_I(STBY_SETTLE_I),
   .FREQ_SETTLE_I(FREQ_SETTLE_I), .RDATA_O(RDATA_O), .POR_REQ_O(POR_REQ_O),
   .MANRST_REQ_O(MANRST_REQ_O), .INTERVAL_IRQ_O(INTERVAL_IRQ_O), .CLK_RESTART_O(CLK_RESTART_O));
